// [common/dtc_pkg.sv]
// dual timer/event counter: register map, field layout, reset values, modes
// assumes byte-wide register port with byte addresses equal to data locations
package dtc_pkg;

  localparam logic [7:0] ADR_T0_DATA = 8'h0D;
  localparam logic [7:0] ADR_T0_CTRL = 8'h0E;
  localparam logic [7:0] ADR_T1_HIGH = 8'h0F;
  localparam logic [7:0] ADR_T1_LOW  = 8'h10;
  localparam logic [7:0] ADR_T1_CTRL = 8'h11;

  localparam int PSC_LSB  = 0;
  localparam int PSC_MSB  = 2;
  localparam int EDGE_BIT = 3;
  localparam int RUN_BIT  = 4;
  localparam int MODE_LSB = 6;
  localparam int MODE_MSB = 7;

  localparam logic [7:0]  CTRL_RST   = 8'h08;
  localparam logic [7:0]  T0_CNT_RST = 8'h00;
  localparam logic [15:0] T1_CNT_RST = 16'h0000;
  localparam logic [7:0]  LBUF_RST   = 8'h00;

  // prescaler code n divides by 2^(n+1); code 1 gives the fixed /4 of counter 1
  localparam logic [2:0] T1_SYS_DIV_SEL = 3'h1;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } dtc_mode_t;

  typedef enum logic {
    PW_IDLE = 1'b0,
    PW_MEAS = 1'b1
  } dtc_pw_t;

  function automatic logic dtc_advance(dtc_mode_t m, logic act, logic itick, logic meas);
    case (m)
      MODE_EVENT: dtc_advance = act;
      MODE_TIMER: dtc_advance = itick;
      MODE_PULSE: dtc_advance = itick && meas;
      default:    dtc_advance = 1'b0;
    endcase
  endfunction

endpackage

// [common/dtc_pin_if.sv]
// dual timer/event counter: synchronised pin level and its edge pulses
// assumes producer and consumer share one clock
`timescale 1ns/1ns
`default_nettype none
interface dtc_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// [hdl/dtc_edge_sync.sv]
// dual timer/event counter: two-flop synchroniser with edge detection
// assumes pin is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module dtc_edge_sync (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  pin,
  dtc_pin_if.src     sync_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign sync_o.level = s2_ff;
  assign sync_o.rise  = s2_ff && !s3_ff;
  assign sync_o.fall  = !s2_ff && s3_ff;
endmodule
`default_nettype wire

// [hdl/dtc_prescaler.sv]
// dual timer/event counter: binary prescaler, divides a tick stream by 2^(sel+1)
// assumes src_tick is a one-cycle pulse in the clk domain
`timescale 1ns/1ns
`default_nettype none
module dtc_prescaler (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        src_tick,
  input  wire logic [2:0]  sel,
  output logic             tick
);
  logic [7:0] div_ff;
  logic [8:0] span;
  logic [7:0] mask;

  assign span = (9'h002 << sel) - 9'h001;
  assign mask = span[7:0];
  // free running: a prescale change takes effect without a restart
  assign tick = src_tick && ((div_ff & mask) == mask);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 8'h00;
    end else if (src_tick) begin
      div_ff <= div_ff + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [hdl/dtc_top.sv]
// dual timer/event counter: 8-bit counter 0 and 16-bit counter 1 with registers
// assumes a one-cycle register port on CLK; pins and RTC are asynchronous
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - counter 0: 8-bit, pin/sys/RTC clocked
// - counter 1: 16-bit, pin/sys-div-4/RTC clocked
// - build option picks time base; RTC needs oscillator
// - buzzer toggles per counter 0 overflow
// - counter 0 write preload, read live
// - control bits 2:0 set prescale
// - control bit 3 picks pin edge
// - control bit 4 runs counter 0
// - control bits 7:6 select mode
// - counter 1 edge bit 3, run bit 4
// - low write buffered; high write loads both
// - high read latches low into buffer
// - event mode uses pin, others internal
// - overflow reloads preload and raises request
// - pulse mode measures one level, clears run
// - measurement held until run set again
// - pulse mode overflow reloads and requests too
// - hardware never clears run outside pulse mode
// - any overflow is a wake-up event
// - cleared enable blocks overflow interrupt
// - stopped write loads counter as well
// - counter clock blocked during its read
module dtc_top
  import dtc_pkg::*;
#(
  parameter bit OSC_INT_RC_RTC = 1'b0,
  parameter bit C0_USE_RTC     = 1'b0,
  parameter bit C1_USE_RTC     = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [7:0]  RDATA,
  input  wire logic        COUNTER0_PIN,
  input  wire logic        COUNTER1_PIN,
  input  wire logic        RTC_OSC,
  input  wire logic        C0_IRQ_ENABLE,
  input  wire logic        C1_IRQ_ENABLE,
  output var  logic        C0_OVERFLOW_FLAG,
  output var  logic        C1_OVERFLOW_FLAG,
  output var  logic        C0_IRQ,
  output var  logic        C1_IRQ,
  output var  logic        WAKEUP,
  output var  logic        BUZZER_FREQ_OUTPUT
);

  // RTC only exists with the internal RC plus RTC oscillator build
  localparam bit C0_RTC = C0_USE_RTC && OSC_INT_RC_RTC;
  localparam bit C1_RTC = C1_USE_RTC && OSC_INT_RC_RTC;

  dtc_pin_if p0 ();
  dtc_pin_if p1 ();
  dtc_pin_if prtc ();

  dtc_edge_sync u_sync0 (
    .clk    (CLK),
    .rst    (RST),
    .pin    (COUNTER0_PIN),
    .sync_o (p0)
  );

  dtc_edge_sync u_sync1 (
    .clk    (CLK),
    .rst    (RST),
    .pin    (COUNTER1_PIN),
    .sync_o (p1)
  );

  dtc_edge_sync u_sync_rtc (
    .clk    (CLK),
    .rst    (RST),
    .pin    (RTC_OSC),
    .sync_o (prtc)
  );

  // counter 0 state
  logic [7:0]  c0_cnt_ff;
  logic [7:0]  c0_pre_ff;
  dtc_mode_t   c0_mode_ff;
  logic        c0_run_ff;
  logic        c0_edge_ff;
  logic [2:0]  c0_psc_ff;
  dtc_pw_t     c0_pw_ff;

  // counter 1 state
  logic [15:0] c1_cnt_ff;
  logic [15:0] c1_pre_ff;
  logic [7:0]  c1_lbuf_ff;
  dtc_mode_t   c1_mode_ff;
  logic        c1_run_ff;
  logic        c1_edge_ff;
  dtc_pw_t     c1_pw_ff;

  logic c0_src;
  logic c0_prescaled_internal_clock;
  logic c1_div4;
  logic c1_prescaled_internal_clock;

  assign c0_src  = C0_RTC ? prtc.rise : 1'b1;

  dtc_prescaler u_psc0 (
    .clk      (CLK),
    .rst      (RST),
    .src_tick (c0_src),
    .sel      (c0_psc_ff),
    .tick     (c0_prescaled_internal_clock)
  );

  dtc_prescaler u_psc1 (
    .clk      (CLK),
    .rst      (RST),
    .src_tick (1'b1),
    .sel      (T1_SYS_DIV_SEL),
    .tick     (c1_div4)
  );

  assign c1_prescaled_internal_clock = C1_RTC ? prtc.rise : c1_div4;

  // register strobes
  logic c0_wr_data;
  logic c0_wr_ctrl;
  logic c0_rd_data;
  logic c1_wr_hi;
  logic c1_wr_lo;
  logic c1_wr_ctrl;
  logic c1_rd_hi;

  assign c0_wr_data = WR && (ADDR == ADR_T0_DATA);
  assign c0_wr_ctrl = WR && (ADDR == ADR_T0_CTRL);
  assign c0_rd_data = RD && (ADDR == ADR_T0_DATA);
  assign c1_wr_hi   = WR && (ADDR == ADR_T1_HIGH);
  assign c1_wr_lo   = WR && (ADDR == ADR_T1_LOW);
  assign c1_wr_ctrl = WR && (ADDR == ADR_T1_CTRL);
  assign c1_rd_hi   = RD && (ADDR == ADR_T1_HIGH);

  // counter 0 advance and overflow
  logic c0_act;
  logic c0_ret;
  logic c0_inc;
  logic c0_ovf;
  logic c0_pw_done;

  assign c0_act = c0_edge_ff ? p0.fall : p0.rise;
  assign c0_ret = c0_edge_ff ? p0.rise : p0.fall;
  // a tick during the read cycle is dropped, so the count can lag
  assign c0_inc = c0_run_ff && !c0_rd_data
                  && dtc_advance(c0_mode_ff, c0_act, c0_prescaled_internal_clock,
                                 c0_pw_ff == PW_MEAS);
  assign c0_ovf = c0_inc && (&c0_cnt_ff);
  assign c0_pw_done = (c0_pw_ff == PW_MEAS) && c0_ret;

  // counter 1 advance and overflow
  logic c1_act;
  logic c1_ret;
  logic c1_inc;
  logic c1_ovf;
  logic c1_pw_done;

  assign c1_act = c1_edge_ff ? p1.fall : p1.rise;
  assign c1_ret = c1_edge_ff ? p1.rise : p1.fall;
  assign c1_inc = c1_run_ff && !c1_rd_hi
                  && dtc_advance(c1_mode_ff, c1_act, c1_prescaled_internal_clock,
                                 c1_pw_ff == PW_MEAS);
  assign c1_ovf = c1_inc && (&c1_cnt_ff);
  assign c1_pw_done = (c1_pw_ff == PW_MEAS) && c1_ret;

  // counter 0 count
  always_ff @(posedge CLK) begin
    if (RST) begin
      c0_cnt_ff <= T0_CNT_RST;
    end else if (c0_ovf) begin
      c0_cnt_ff <= c0_pre_ff;
    end else if (c0_inc) begin
      c0_cnt_ff <= c0_cnt_ff + 8'h01;
    end else if (c0_wr_data && !c0_run_ff) begin
      c0_cnt_ff <= WDATA;
    end
  end

  // counter 0 preload
  always_ff @(posedge CLK) begin
    if (RST) begin
      c0_pre_ff <= T0_CNT_RST;
    end else if (c0_wr_data) begin
      c0_pre_ff <= WDATA;
    end
  end

  // counter 0 control; a software write beats the hardware run clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      c0_mode_ff <= dtc_mode_t'(CTRL_RST[MODE_MSB:MODE_LSB]);
      c0_run_ff  <= CTRL_RST[RUN_BIT];
      c0_edge_ff <= CTRL_RST[EDGE_BIT];
      c0_psc_ff  <= CTRL_RST[PSC_MSB:PSC_LSB];
    end else if (c0_wr_ctrl) begin
      c0_mode_ff <= dtc_mode_t'(WDATA[MODE_MSB:MODE_LSB]);
      c0_run_ff  <= WDATA[RUN_BIT];
      c0_edge_ff <= WDATA[EDGE_BIT];
      c0_psc_ff  <= WDATA[PSC_MSB:PSC_LSB];
    end else if (c0_pw_done && c0_mode_ff == MODE_PULSE) begin
      c0_run_ff  <= 1'b0;
    end
  end

  // counter 0 pulse width state
  always_ff @(posedge CLK) begin
    if (RST) begin
      c0_pw_ff <= PW_IDLE;
    end else if (c0_mode_ff != MODE_PULSE || !c0_run_ff) begin
      c0_pw_ff <= PW_IDLE;
    end else begin
      case (c0_pw_ff)
        PW_IDLE: begin
          if (c0_act) begin
            c0_pw_ff <= PW_MEAS;
          end
        end
        PW_MEAS: begin
          if (c0_ret) begin
            c0_pw_ff <= PW_IDLE;
          end
        end
        default: c0_pw_ff <= PW_IDLE;
      endcase
    end
  end

  // counter 1 count
  always_ff @(posedge CLK) begin
    if (RST) begin
      c1_cnt_ff <= T1_CNT_RST;
    end else if (c1_ovf) begin
      c1_cnt_ff <= c1_pre_ff;
    end else if (c1_inc) begin
      c1_cnt_ff <= c1_cnt_ff + 16'h0001;
    end else if (c1_wr_hi && !c1_run_ff) begin
      c1_cnt_ff <= {WDATA, c1_lbuf_ff};
    end
  end

  // counter 1 preload, loaded whole only by the high byte write
  always_ff @(posedge CLK) begin
    if (RST) begin
      c1_pre_ff <= T1_CNT_RST;
    end else if (c1_wr_hi) begin
      c1_pre_ff <= {WDATA, c1_lbuf_ff};
    end
  end

  // low byte buffer, shared by write and read paths
  always_ff @(posedge CLK) begin
    if (RST) begin
      c1_lbuf_ff <= LBUF_RST;
    end else if (c1_wr_lo) begin
      c1_lbuf_ff <= WDATA;
    end else if (c1_rd_hi) begin
      c1_lbuf_ff <= c1_cnt_ff[7:0];
    end
  end

  // counter 1 control
  always_ff @(posedge CLK) begin
    if (RST) begin
      c1_mode_ff <= dtc_mode_t'(CTRL_RST[MODE_MSB:MODE_LSB]);
      c1_run_ff  <= CTRL_RST[RUN_BIT];
      c1_edge_ff <= CTRL_RST[EDGE_BIT];
    end else if (c1_wr_ctrl) begin
      c1_mode_ff <= dtc_mode_t'(WDATA[MODE_MSB:MODE_LSB]);
      c1_run_ff  <= WDATA[RUN_BIT];
      c1_edge_ff <= WDATA[EDGE_BIT];
    end else if (c1_pw_done && c1_mode_ff == MODE_PULSE) begin
      c1_run_ff  <= 1'b0;
    end
  end

  // counter 1 pulse width state
  always_ff @(posedge CLK) begin
    if (RST) begin
      c1_pw_ff <= PW_IDLE;
    end else if (c1_mode_ff != MODE_PULSE || !c1_run_ff) begin
      c1_pw_ff <= PW_IDLE;
    end else begin
      case (c1_pw_ff)
        PW_IDLE: begin
          if (c1_act) begin
            c1_pw_ff <= PW_MEAS;
          end
        end
        PW_MEAS: begin
          if (c1_ret) begin
            c1_pw_ff <= PW_IDLE;
          end
        end
        default: c1_pw_ff <= PW_IDLE;
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        ADR_T0_DATA: RDATA <= c0_cnt_ff;
        ADR_T0_CTRL: RDATA <= {c0_mode_ff, 1'b0, c0_run_ff,
                               c0_edge_ff, c0_psc_ff};
        ADR_T1_HIGH: RDATA <= c1_cnt_ff[15:8];
        ADR_T1_LOW:  RDATA <= c1_lbuf_ff;
        ADR_T1_CTRL: RDATA <= {c1_mode_ff, 1'b0, c1_run_ff,
                               c1_edge_ff, 3'h0};
        default:     RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // overflow requests towards the interrupt controller
  always_ff @(posedge CLK) begin
    if (RST) begin
      C0_OVERFLOW_FLAG <= 1'b0;
      C1_OVERFLOW_FLAG <= 1'b0;
      C0_IRQ           <= 1'b0;
      C1_IRQ           <= 1'b0;
    end else begin
      C0_OVERFLOW_FLAG <= c0_ovf;
      C1_OVERFLOW_FLAG <= c1_ovf;
      C0_IRQ           <= c0_ovf && C0_IRQ_ENABLE;
      C1_IRQ           <= c1_ovf && C1_IRQ_ENABLE;
    end
  end

  // wake-up ignores the enables: halt release is independent of service
  always_ff @(posedge CLK) begin
    if (RST) begin
      WAKEUP <= 1'b0;
    end else begin
      WAKEUP <= c0_ovf || c1_ovf;
    end
  end

  // one toggle per overflow gives half the overflow rate
  always_ff @(posedge CLK) begin
    if (RST) begin
      BUZZER_FREQ_OUTPUT <= 1'b0;
    end else if (c0_ovf) begin
      BUZZER_FREQ_OUTPUT <= !BUZZER_FREQ_OUTPUT;
    end
  end

endmodule
`default_nettype wire

// [tb/dtc_top_chk.sv]
// dual timer/event counter: port-level assertions on the top module
// assumes one clock CLK and synchronous active-high RST
`timescale 1ns/1ns
`default_nettype none
module dtc_top_chk
  import dtc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] ADDR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       C0_IRQ_ENABLE,
  input wire logic       C1_IRQ_ENABLE,
  input wire logic       C0_OVERFLOW_FLAG,
  input wire logic       C1_OVERFLOW_FLAG,
  input wire logic       C0_IRQ,
  input wire logic       C1_IRQ,
  input wire logic       WAKEUP,
  input wire logic       BUZZER_FREQ_OUTPUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read slot");
  c0_unused_a: assert property ($past(RD) && $past(ADDR) == ADR_T0_CTRL |-> !RDATA[5])
    else $error("counter 0 unused bit read as one");
  c1_unused_a: assert property ($past(RD) && $past(ADDR) == ADR_T1_CTRL
    |-> RDATA[5] == 1'b0 && RDATA[2:0] == 3'h0)
    else $error("counter 1 unused bits read as one");
  irq0_cause_a: assert property (C0_IRQ |-> C0_OVERFLOW_FLAG)
    else $error("counter 0 request without overflow");
  irq0_mask_a: assert property (!C0_IRQ_ENABLE && !$past(C0_IRQ_ENABLE) |-> !C0_IRQ)
    else $error("counter 0 request while disabled");
  irq1_mask_a: assert property (!C1_IRQ_ENABLE && !$past(C1_IRQ_ENABLE) |-> !C1_IRQ)
    else $error("counter 1 request while disabled");
  wake_any_a: assert property (WAKEUP == (C0_OVERFLOW_FLAG || C1_OVERFLOW_FLAG))
    else $error("wake-up does not follow overflow");
  buzz_toggle_a: assert property (C0_OVERFLOW_FLAG && !$past(RST)
    |-> BUZZER_FREQ_OUTPUT != $past(BUZZER_FREQ_OUTPUT))
    else $error("buzzer did not toggle on overflow");
  buzz_hold_a: assert property (!C0_OVERFLOW_FLAG && !$past(RST)
    |-> $stable(BUZZER_FREQ_OUTPUT))
    else $error("buzzer moved without overflow");
  flag_pulse_a: assert property (C1_OVERFLOW_FLAG |=> !C1_OVERFLOW_FLAG)
    else $error("counter 1 overflow longer than one cycle");
endmodule
`default_nettype wire

// [tb/dtc_pin_drv.sv]
// dual timer/event counter: external pulse source for one count pin
// assumes pulses are timed on the bench clock; pin idles low
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_drv (
  input  wire logic clk,
  output var  logic pin
);
  initial pin = 1'b0;
  // push-pull source: the level is always driven, so no float case
  task automatic pulse(input int hi, input int lo);
    @(posedge clk);
    pin <= 1'b1;
    repeat (hi) @(posedge clk);
    pin <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/dtc_top_test.sv]
// dual timer/event counter: self-checking bench, one task per scenario
// assumes default build options, system clock time base, RTC unused
`timescale 1ns/1ns
`default_nettype none
module dtc_top_test;
  import dtc_pkg::*;
  logic       CLK, RST, WR, RD, C0_IRQ_ENABLE, C1_IRQ_ENABLE;
  logic [7:0] ADDR, WDATA, RDATA;
  logic       C0_OVERFLOW_FLAG, C1_OVERFLOW_FLAG, C0_IRQ, C1_IRQ, WAKEUP, BUZZER_FREQ_OUTPUT;
  logic       pin0, pin1;
  int         n_fail = 0;
  int         n_compared = 0;

  dtc_pin_drv u_p0 (.clk(CLK), .pin(pin0));
  dtc_pin_drv u_p1 (.clk(CLK), .pin(pin1));
  dtc_top u_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .COUNTER0_PIN(pin0), .COUNTER1_PIN(pin1), .RTC_OSC(1'b0),
    .C0_IRQ_ENABLE(C0_IRQ_ENABLE), .C1_IRQ_ENABLE(C1_IRQ_ENABLE),
    .C0_OVERFLOW_FLAG(C0_OVERFLOW_FLAG), .C1_OVERFLOW_FLAG(C1_OVERFLOW_FLAG),
    .C0_IRQ(C0_IRQ), .C1_IRQ(C1_IRQ), .WAKEUP(WAKEUP),
    .BUZZER_FREQ_OUTPUT(BUZZER_FREQ_OUTPUT));

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  // returns cycles until the overflow pulse; a hang counts as a mismatch
  task automatic wait_ovf(input bit c1, output int cyc);
    cyc = 0;
    do begin
      @(posedge CLK);
      #1 cyc++;
      if (cyc > 400) begin
        n_fail++;
        $display("unexpected overflow wait expected %0d seen %0d", 400, cyc);
        end_of_test();
      end
    end while ((c1 ? C1_OVERFLOW_FLAG : C0_OVERFLOW_FLAG) !== 1'b1);
  endtask

  task automatic t_reset_vals();
    rchk("t0 control", ADR_T0_CTRL, CTRL_RST);
    rchk("t1 control", ADR_T1_CTRL, CTRL_RST);
    rchk("t0 count", ADR_T0_DATA, T0_CNT_RST);
    rchk("unmapped", 8'h12, 8'h00);
    $display("test reset_vals done");
  endtask
  task automatic t_ctrl_unused();
    wr(ADR_T0_CTRL, 8'h27);
    rchk("t0 control bits", ADR_T0_CTRL, 8'h07);
    wr(ADR_T1_CTRL, 8'h2F);
    rchk("t1 control bits", ADR_T1_CTRL, 8'h08);
    $display("test ctrl_unused done");
  endtask
  task automatic t_c0_timer();
    int c;
    logic b;
    wr(ADR_T0_DATA, 8'hFE);
    rchk("t0 stopped load", ADR_T0_DATA, 8'hFE);
    C0_IRQ_ENABLE <= 1'b1;
    wr(ADR_T0_CTRL, 8'h90);
    wait_ovf(0, c);
    chk("c0 irq", 8'h01, {7'h0, C0_IRQ});
    chk("wakeup", 8'h01, {7'h0, WAKEUP});
    for (int p = 0; p < 3; p++) begin
      wr(ADR_T0_CTRL, 8'h90 | p[7:0]);
      wait_ovf(0, c);
      b = BUZZER_FREQ_OUTPUT;
      wait_ovf(0, c);
      chk("c0 overflow spacing", 8'(2 << (p + 1)), 8'(c));
      chk("buzzer level", {7'h0, ~b}, {7'h0, BUZZER_FREQ_OUTPUT});
    end
    // overflow still happens with the enable low, only the request is held back
    C0_IRQ_ENABLE <= 1'b0;
    wait_ovf(0, c);
    chk("c0 irq masked", 8'h00, {7'h0, C0_IRQ});
    $display("test c0_timer done");
  endtask
  task automatic t_c0_stop();
    logic [7:0] d;
    wr(ADR_T0_CTRL, 8'h80);
    rd(ADR_T0_DATA, d);
    repeat (30) @(posedge CLK);
    rchk("t0 halted", ADR_T0_DATA, d);
    wr(ADR_T0_CTRL, 8'h10);
    repeat (30) @(posedge CLK);
    rchk("t0 mode off", ADR_T0_DATA, d);
    $display("test c0_stop done");
  endtask
  task automatic t_c1_pair();
    wr(ADR_T1_LOW, 8'h34);
    wr(ADR_T1_HIGH, 8'h12);
    wr(ADR_T1_LOW, 8'h56);
    rchk("t1 high", ADR_T1_HIGH, 8'h12);
    rchk("t1 low latched", ADR_T1_LOW, 8'h34);
    $display("test c1_pair done");
  endtask
  task automatic t_c1_event();
    int c;
    wr(ADR_T1_LOW, 8'hFE);
    wr(ADR_T1_HIGH, 8'hFF);
    C1_IRQ_ENABLE <= 1'b0;
    wr(ADR_T1_CTRL, 8'h50);
    u_p1.pulse(3, 3);
    rchk("t1 high event", ADR_T1_HIGH, 8'hFF);
    rchk("t1 low event", ADR_T1_LOW, 8'hFF);
    // request is a one-cycle pulse: judge it in the overflow cycle itself
    fork
      u_p1.pulse(3, 3);
      begin
        wait_ovf(1, c);
        chk("c1 irq masked", 8'h00, {7'h0, C1_IRQ});
      end
    join
    rchk("t1 high reload", ADR_T1_HIGH, 8'hFF);
    rchk("t1 low reload", ADR_T1_LOW, 8'hFE);
    rchk("t1 run kept", ADR_T1_CTRL, 8'h50);
    wr(ADR_T1_LOW, 8'h00);
    wr(ADR_T1_HIGH, 8'h80);
    rchk("t1 running write", ADR_T1_HIGH, 8'hFF);
    $display("test c1_event done");
  endtask
  task automatic t_c0_pulse();
    logic [7:0] d, e;
    wr(ADR_T0_CTRL, 8'h00);
    wr(ADR_T0_DATA, 8'h00);
    wr(ADR_T0_CTRL, 8'hD0);
    u_p0.pulse(20, 10);
    rchk("pw run cleared", ADR_T0_CTRL, 8'hC0);
    // 20 cycles of high level at a /2 prescale give exactly 10 counts
    rd(ADR_T0_DATA, d);
    chk("pw counted", 8'h0A, d);
    u_p0.pulse(20, 10);
    rchk("pw held", ADR_T0_DATA, d);
    wr(ADR_T0_CTRL, 8'hD0);
    u_p0.pulse(20, 10);
    rd(ADR_T0_DATA, e);
    chk("pw rearmed", 8'h14, e);
    $display("test c0_pulse done");
  endtask

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    RST = 1'b1;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    C0_IRQ_ENABLE = 1'b0;
    C1_IRQ_ENABLE = 1'b0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    t_reset_vals();
    t_ctrl_unused();
    t_c1_pair();
    t_c0_timer();
    t_c0_stop();
    t_c1_event();
    t_c0_pulse();
    end_of_test();
  end
endmodule

bind dtc_top dtc_top_chk u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
  .C0_IRQ_ENABLE(C0_IRQ_ENABLE), .C1_IRQ_ENABLE(C1_IRQ_ENABLE),
  .C0_OVERFLOW_FLAG(C0_OVERFLOW_FLAG), .C1_OVERFLOW_FLAG(C1_OVERFLOW_FLAG),
  .C0_IRQ(C0_IRQ), .C1_IRQ(C1_IRQ), .WAKEUP(WAKEUP),
  .BUZZER_FREQ_OUTPUT(BUZZER_FREQ_OUTPUT));
`default_nettype wire
